// file: rtl/gsu_regs.sv
// Global status, transaction counter and reply-delay register bank
`timescale 1ns/1ps
`default_nettype none
module gsu_regs
  import gsu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Decoded access from the serial frame logic
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [ADDR_W-1:0] accAddr,
  input wire logic [DATA_W-1:0] accWrData,
  // Read answer
  output logic [DATA_W-1:0] rdData_reg,
  output logic rdValid_reg,
  // Reply pacing
  input wire logic bitTick,
  output logic replyGo_reg,
  output logic replyBusy_reg,
  // Power stage status
  input wire logic driverShutdown,
  input wire logic chargePumpUv,
  output logic powerStageEnable_reg
);
  // *****************************************************************
  // State
  // *****************************************************************
  logic resetFlag_reg, resetFlag_next;
  logic drvErrFlag_reg, drvErrFlag_next;
  logic uvFlag_reg, uvFlag_next;
  logic [COUNT_W-1:0] txCount_reg, txCount_next;
  logic [DELAY_W-1:0] replyDelayField_reg, replyDelayField_next;
  logic [DATA_W-1:0] rdData_next;
  logic rdValid_next;
  logic replyGo_next;
  logic replyBusy_next;
  logic powerStageEnable_next;
  logic [STATUS_W-1:0] statusView;
  logic [BITTIME_W-1:0] bitTimes;
  logic [DELAY_W-1:0] multiplier;
  logic isWrite;
  logic isRead;

  gsu_delay_if dly ();

  gsu_reply_timer gsu_reply_timer_i (
    .clk(clk),
    .rst_n(rst_n),
    .dly(dly)
  );

  assign isWrite = accValid & accWrite;
  assign isRead = accValid & ~accWrite;

  // *****************************************************************
  // Reply delay decode
  // *****************************************************************
  // Each even/odd pair maps to the odd value; 0 and 1 both mean one unit
  always_comb begin
    if (replyDelayField_reg <= DELAY_MIN_PAIR) begin
      multiplier = DELAY_ODD;
    end else begin
      multiplier = replyDelayField_reg | DELAY_ODD;
    end
    bitTimes = BITTIME_W'(multiplier * BITS_PER_UNIT);
  end

  assign dly.start = isRead;
  assign dly.bitTick = bitTick;
  assign dly.bitTimes = bitTimes;

  // *****************************************************************
  // Status flags
  // *****************************************************************
  // Set beats clear: a shutdown seen in the clearing cycle stays flagged
  always_comb begin
    resetFlag_next = resetFlag_reg;
    drvErrFlag_next = drvErrFlag_reg;
    if (isWrite && accAddr == STATUS_ADDR) begin
      if (accWrData[RESET_BIT]) begin
        resetFlag_next = 1'b0;
      end
      if (accWrData[DRVERR_BIT] && !driverShutdown) begin
        drvErrFlag_next = 1'b0;
      end
    end
    if (driverShutdown) begin
      drvErrFlag_next = 1'b1;
    end
    uvFlag_next = chargePumpUv;
  end

  assign statusView = {uvFlag_reg, drvErrFlag_reg, resetFlag_reg};

  // *****************************************************************
  // Counter, configuration, read answer
  // *****************************************************************
  always_comb begin
    txCount_next = txCount_reg;
    replyDelayField_next = replyDelayField_reg;
    rdData_next = rdData_reg;
    rdValid_next = 1'b0;
    if (isWrite) begin
      txCount_next = txCount_reg + COUNT_STEP;
      if (accAddr == DELAY_ADDR) begin
        replyDelayField_next = accWrData[DELAY_LSB +: DELAY_W];
      end
    end
    if (isRead) begin
      rdValid_next = 1'b1;
      rdData_next = '0;
      case (accAddr)
        STATUS_ADDR: begin
          rdData_next[STATUS_W-1:0] = statusView;
        end
        COUNT_ADDR: begin
          rdData_next[COUNT_W-1:0] = txCount_reg;
        end
        default: begin
          rdData_next = '0;
        end
      endcase
    end
    replyGo_next = dly.done;
    replyBusy_next = dly.busy | isRead;
    // Undervoltage or a latched shutdown keeps the bridge off
    powerStageEnable_next = ~(chargePumpUv | drvErrFlag_next);
  end

  // *****************************************************************
  // Registers
  // *****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resetFlag_reg <= LATCH_RESET[RESET_BIT];
      drvErrFlag_reg <= 1'b0;
      uvFlag_reg <= 1'b0;
      txCount_reg <= COUNT_RESET;
      replyDelayField_reg <= DELAY_RESET;
      rdData_reg <= '0;
      rdValid_reg <= 1'b0;
      replyGo_reg <= 1'b0;
      replyBusy_reg <= 1'b0;
      powerStageEnable_reg <= 1'b0;
    end else begin
      resetFlag_reg <= resetFlag_next;
      drvErrFlag_reg <= drvErrFlag_next;
      uvFlag_reg <= uvFlag_next;
      txCount_reg <= txCount_next;
      replyDelayField_reg <= replyDelayField_next;
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
      replyGo_reg <= replyGo_next;
      replyBusy_reg <= replyBusy_next;
      powerStageEnable_reg <= powerStageEnable_next;
    end
  end
endmodule : gsu_regs
`default_nettype wire

// file: rtl/gsu_pkg.sv
// Constants and types for the global status and reply-delay registers
// *****************************************************************
// Functional notes
// *****************************************************************
// Functional notes
// - Writing one to status bit 0 or 1 clears that flag; those flags otherwise hold.
// - Bit 0 is set after chip reset and holds until cleared.
// - Chip reset returns every register to reset value and sets bit 0.
// - Bit 1 sets when the power stage shut down on overheat or short.
// - Clearing bit 1 is ignored while its shutdown cause persists.
// - Bit 2 shows charge pump undervoltage; power stage stays off then.
// - Bit 2 follows the live undervoltage level and needs no clearing.
// - Eight-bit counter increments once per successful counted access.
// - Reads leave the counter unchanged; only counted accesses move it.
// - Counter wraps from 255 to 0, never saturating.
// - Write-only bits 11:8 set reply delay; 0 and 1 give 8 bit times.
// - Values 10 and 11 give 11*8 bit times; host stays silent then.
// - Pairs 2/3, 4/5, 6/7, 8/9 give 3, 5, 7, 9 times 8 bits.
`default_nettype none
package gsu_pkg;
  // *****************************************************************
  // Register map
  // *****************************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 7'h01;
  localparam logic [ADDR_W-1:0] COUNT_ADDR = 7'h02;
  localparam logic [ADDR_W-1:0] DELAY_ADDR = 7'h03;
  // *****************************************************************
  // Fields and reset values
  // *****************************************************************
  localparam int STATUS_W = 3;
  localparam int RESET_BIT = 0;
  localparam int DRVERR_BIT = 1;
  localparam int UV_BIT = 2;
  localparam logic [1:0] LATCH_RESET = 2'h1;
  localparam int COUNT_W = 8;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 8'h01;
  localparam int DELAY_LSB = 8;
  localparam int DELAY_W = 4;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 4'h0;
  localparam logic [DELAY_W-1:0] DELAY_MIN_PAIR = 4'h1;
  localparam logic [DELAY_W-1:0] DELAY_ODD = 4'h1;
  // *****************************************************************
  // Timing
  // *****************************************************************
  localparam int BITS_PER_UNIT = 8;
  localparam int BITTIME_W = 7;
  localparam logic [BITTIME_W-1:0] BITTIME_ZERO = 7'h00;
  localparam logic [BITTIME_W-1:0] BITTIME_ONE = 7'h01;
  typedef enum logic {GSU_IDLE, GSU_WAIT} gsu_timer_state_type;
endpackage : gsu_pkg
`default_nettype wire

// file: rtl/gsu_delay_if.sv
// Interface between register bank and reply-delay timer
`timescale 1ns/1ps
`default_nettype none
interface gsu_delay_if;
  import gsu_pkg::*;
  logic start;
  logic bitTick;
  logic [BITTIME_W-1:0] bitTimes;
  logic done;
  logic busy;
  modport bank (output start, output bitTick, output bitTimes,
                input done, input busy);
  modport timer (input start, input bitTick, input bitTimes,
                 output done, output busy);
endinterface : gsu_delay_if
`default_nettype wire

// file: rtl/gsu_reply_timer.sv
// Counts bit times from a read request until the reply may start
`timescale 1ns/1ps
`default_nettype none
module gsu_reply_timer
  import gsu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link to the register bank
  gsu_delay_if.timer dly
);
  gsu_timer_state_type state_reg, state_next;
  logic [BITTIME_W-1:0] left_reg, left_next;
  logic done_reg, done_next;

  always_comb begin
    state_next = state_reg;
    left_next = left_reg;
    done_next = 1'b0;
    case (state_reg)
      GSU_IDLE: begin
        if (dly.start) begin
          state_next = GSU_WAIT;
          left_next = dly.bitTimes;
        end
      end
      GSU_WAIT: begin
        if (dly.bitTick) begin
          left_next = left_reg - BITTIME_ONE;
          if (left_reg == BITTIME_ONE) begin
            state_next = GSU_IDLE;
            done_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = GSU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= GSU_IDLE;
      left_reg <= BITTIME_ZERO;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      left_reg <= left_next;
      done_reg <= done_next;
    end
  end

  assign dly.done = done_reg;
  assign dly.busy = (state_reg == GSU_WAIT);
endmodule : gsu_reply_timer
`default_nettype wire

// file: tb/gsu_host_model.sv
// Host controller model: register accesses and serial bit pacing
`timescale 1ns/1ps
`default_nettype none
module gsu_host_model
  import gsu_pkg::*;
#(parameter int TICK_DIV = 4)
(
  // Clock
  input wire logic clk,
  // Access and answer
  output logic accValid,
  output logic accWrite,
  output logic [ADDR_W-1:0] accAddr,
  output logic [DATA_W-1:0] accWrData,
  input wire logic [DATA_W-1:0] rdData_reg,
  input wire logic replyGo_reg,
  // Bit time pacing
  output logic bitTick
);
  int tickCnt = 0;
  initial {accValid, accWrite, accAddr, accWrData} = '0;
  always @(posedge clk) begin
    tickCnt <= (tickCnt == TICK_DIV - 1) ? 0 : tickCnt + 1;
    bitTick <= (tickCnt == TICK_DIV - 1);
  end
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
      output int ticks);
    ticks = 0;
    @(posedge clk);
    {accValid, accWrite, accAddr, accWrData} <= {1'h1, w, a, d};
    @(posedge clk);
    // Released lines do not keep their last value
    {accValid, accAddr, accWrData} <= {1'h0, ~a, ~d};
    #1;
    q = rdData_reg;
    // A reply that never comes is left to the bench watchdog
    while (!w && !replyGo_reg) begin
      ticks += bitTick;
      @(posedge clk);
      #1;
    end
  endtask : access
endmodule : gsu_host_model
`default_nettype wire

// file: tb/gsu_regs_checker.sv
// Port assertions for the register bank
`timescale 1ns/1ps
`default_nettype none
module gsu_regs_checker
  import gsu_pkg::*;
(
  // Clock, reset and access
  input wire logic clk,
  input wire logic rst_n,
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [ADDR_W-1:0] accAddr,
  // Outputs and status inputs
  input wire logic [DATA_W-1:0] rdData_reg,
  input wire logic rdValid_reg,
  input wire logic replyGo_reg,
  input wire logic replyBusy_reg,
  input wire logic driverShutdown,
  input wire logic chargePumpUv,
  input wire logic powerStageEnable_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [COUNT_W-1:0] wrCnt_reg;
  wire logic rd = accValid && !accWrite;
  wire logic rdSt = rd && accAddr == STATUS_ADDR;
  // Own count of writes, since the design hides its counter
  always_ff @(posedge clk)
    wrCnt_reg <= !rst_n ? COUNT_RESET
      : wrCnt_reg + ((accValid && accWrite) ? COUNT_STEP : COUNT_RESET);
  sequence seqAnswer;
    rdValid_reg ##1 (rdValid_reg == $past(rd));
  endsequence
  sequence seqGoEnd;
    !replyBusy_reg ##1 !replyGo_reg;
  endsequence
  chk_reset_clears: assert property ($rose(rst_n) |-> !replyBusy_reg
    && !rdValid_reg && !powerStageEnable_reg) else $error("not reset");
  chk_read_answer: assert property (rd |=> seqAnswer)
    else $error("read not answered");
  chk_busy_opens: assert property (rd && !replyBusy_reg
    |=> replyBusy_reg) else $error("reply window not opened");
  chk_go_closes: assert property (replyGo_reg |->
    $past(replyBusy_reg) ##0 seqGoEnd) else $error("bad reply start");
  chk_power_uv: assert property (chargePumpUv |=> !powerStageEnable_reg)
    else $error("power stage on in undervoltage");
  chk_uv_live: assert property (rdSt && $past(rst_n) |=>
    rdData_reg[UV_BIT] == $past(chargePumpUv, 2)) else $error("uv flag");
  chk_drv_sticky: assert property ($past(driverShutdown) && rdSt
    && $past(rst_n) |=> rdData_reg[DRVERR_BIT]) else $error("drv flag");
  chk_count_value: assert property (rd && accAddr == COUNT_ADDR
    |=> rdData_reg[COUNT_W-1:0] == $past(wrCnt_reg)) else $error("count");
endmodule : gsu_regs_checker
bind gsu_regs gsu_regs_checker gsu_regs_checker_i (.clk, .rst_n, .accValid,
  .accWrite, .accAddr, .rdData_reg, .rdValid_reg, .replyGo_reg,
  .replyBusy_reg, .driverShutdown, .chargePumpUv, .powerStageEnable_reg);
`default_nettype wire

// file: tb/gsu_regs_tb.sv
// Testbench for the global status and reply-delay register bank
`timescale 1ns/1ps
`default_nettype none
module gsu_regs_tb;
  import gsu_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic drvSd = 1'h0;
  logic cpUv = 1'h0;
  logic accValid, accWrite, bitTick, rdValid, go, busy, pse;
  logic [ADDR_W-1:0] accAddr;
  logic [DATA_W-1:0] accWrData, rdData, q;
  int failures = 0;
  int checks_done = 0;
  int nWr = 0;
  int ticks;
  always #2 clk = ~clk;
  gsu_regs gsu_regs_i (.clk, .rst_n, .accValid, .accWrite, .accAddr,
    .accWrData, .rdData_reg(rdData), .rdValid_reg(rdValid), .bitTick,
    .replyGo_reg(go), .replyBusy_reg(busy), .driverShutdown(drvSd),
    .chargePumpUv(cpUv), .powerStageEnable_reg(pse));
  gsu_host_model gsu_host_model_i (.clk, .accValid, .accWrite, .accAddr,
    .accWrData, .rdData_reg(rdData), .replyGo_reg(go), .bitTick);
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
      input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [ADDR_W-1:0] a);
    gsu_host_model_i.access(1'h0, a, 32'h0, q, ticks);
  endtask : rd
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    gsu_host_model_i.access(1'h1, a, d, q, ticks);
    nWr++;
  endtask : wr
  task automatic t_status;
    rd(STATUS_ADDR);
    check("status", q, 32'h1);
    wr(STATUS_ADDR, 32'hFFFF_FFF8);
    rd(STATUS_ADDR);
    check("status", q, 32'h1);
    wr(STATUS_ADDR, 32'h1);
    rd(STATUS_ADDR);
    check("status", q, 32'h0);
    rd(DELAY_ADDR);
    check("delay", q, 32'h0);
  endtask : t_status
  task automatic t_fault;
    @(posedge clk);
    {drvSd, cpUv} <= 2'h3;
    wr(STATUS_ADDR, 32'h2);
    rd(STATUS_ADDR);
    check("status", q, 32'h6);
    check("power", {31'h0, pse}, 32'h0);
    @(posedge clk);
    {drvSd, cpUv} <= 2'h0;
    repeat (2) @(posedge clk);
    rd(STATUS_ADDR);
    check("status", q, 32'h2);
    wr(STATUS_ADDR, 32'h2);
    rd(STATUS_ADDR);
    check("status", q, 32'h0);
    check("power", {31'h0, pse}, 32'h1);
  endtask : t_fault
  task automatic t_count;
    repeat (300) wr(7'h7F, 32'hFFFF_FFFF);
    wr(COUNT_ADDR, 32'hAA);
    rd(COUNT_ADDR);
    check("count", q, {24'h0, 8'(nWr)});
    rd(COUNT_ADDR);
    check("count", q, {24'h0, 8'(nWr)});
  endtask : t_count
  task automatic t_delay;
    for (int v = 0; v < 12; v++) begin
      wr(DELAY_ADDR, 32'(v) << DELAY_LSB);
      rd(STATUS_ADDR);
      check("ticks", ticks, (v < 2) ? 8 : (v | 1) * 8);
    end
  endtask : t_delay
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd(COUNT_ADDR);
    check("count", q, 32'h0);
    check("ticks", ticks, 32'h8);
    rd(STATUS_ADDR);
    check("status", q, 32'h1);
  endtask : t_reset
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_status;
    t_fault;
    t_count;
    t_delay;
    t_reset;
    tally_and_finish;
  end
  initial begin
    #100000;
    failures++;
    tally_and_finish;
  end
endmodule : gsu_regs_tb
`default_nettype wire
